// [rtl/core_interrupt_sequencer.sv]
// core_interrupt_sequencer: interrupt flags, enables, entry and return sequencing for an 8-bit core
// assumes core logic on clk_in drives pc_in, ctx_in and a one-clock return_from_irq_op_in pulse,
// peripheral events are same-clock pulses, core event pins are asynchronous
//
// Operation
// - Any reset leaves global enable clear, so nothing vectors until software sets it.
// - Vectoring needs global and own enable; peripheral sources also need the group enable.
// - Every event sets its flag whatever the enables say.
// - Taking an enabled event flushes the prefetched instruction and clears global enable.
// - Entry pushes the current program counter onto the return stack.
// - Entry copies critical core registers to the shadow set by hardware.
// - Entry loads the program counter with the fixed vector 0004h.
// - With global enable clear, events set flags but never redirect execution.
// - Return pops the address, restores shadow context and sets global enable.
// - An enabled event seen while global enable is clear stays pending until re-enabled.
// - Synchronous event to vector execution takes three or four instruction cycles.
// - Asynchronous event to vector execution takes three to five instruction cycles.
module core_interrupt_sequencer
  import irq_seq_pkg::*;
(
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic [7:0]                s_axi_awaddr_in,
  input  wire logic                      s_axi_awvalid_in,
  output logic                           s_axi_awready_out,
  input  wire logic [31:0]               s_axi_wdata_in,
  input  wire logic [3:0]                s_axi_wstrb_in,
  input  wire logic                      s_axi_wvalid_in,
  output logic                           s_axi_wready_out,
  output logic [1:0]                     s_axi_bresp_out,
  output logic                           s_axi_bvalid_out,
  input  wire logic                      s_axi_bready_in,
  input  wire logic [7:0]                s_axi_araddr_in,
  input  wire logic                      s_axi_arvalid_in,
  output logic                           s_axi_arready_out,
  output logic [31:0]                    s_axi_rdata_out,
  output logic [1:0]                     s_axi_rresp_out,
  output logic                           s_axi_rvalid_out,
  input  wire logic                      s_axi_rready_in,
  input  wire logic [NUM_PERIPH_EVT-1:0] periph_evt_in,
  input  wire logic [NUM_CORE_EVT-1:0]   core_evt_in,
  input  wire logic                      return_from_irq_op_in,
  input  wire logic [14:0]               pc_in,
  input  wire core_ctx_t                 ctx_in,
  output core_cmd_t                      cmd_out,
  output core_ctx_t                      shadow_ctx_out,
  output logic                           gie_out,
  output logic                           irq_out
);
  reg_req_t                  req;
  logic [7:0]                rd_data;
  logic                      rd_err, wr_err;
  logic [NUM_CORE_EVT-1:0]   core_lvl;

  axil_slave u_axil (
    .clk_in            (clk_in),
    .sys_rst_in        (sys_rst_in),
    .s_axi_awaddr_in   (s_axi_awaddr_in),
    .s_axi_awvalid_in  (s_axi_awvalid_in),
    .s_axi_awready_out (s_axi_awready_out),
    .s_axi_wdata_in    (s_axi_wdata_in),
    .s_axi_wstrb_in    (s_axi_wstrb_in),
    .s_axi_wvalid_in   (s_axi_wvalid_in),
    .s_axi_wready_out  (s_axi_wready_out),
    .s_axi_bresp_out   (s_axi_bresp_out),
    .s_axi_bvalid_out  (s_axi_bvalid_out),
    .s_axi_bready_in   (s_axi_bready_in),
    .s_axi_araddr_in   (s_axi_araddr_in),
    .s_axi_arvalid_in  (s_axi_arvalid_in),
    .s_axi_arready_out (s_axi_arready_out),
    .s_axi_rdata_out   (s_axi_rdata_out),
    .s_axi_rresp_out   (s_axi_rresp_out),
    .s_axi_rvalid_out  (s_axi_rvalid_out),
    .s_axi_rready_in   (s_axi_rready_in),
    .req_out           (req),
    .rd_data_in        (rd_data),
    .rd_err_in         (rd_err),
    .wr_err_in         (wr_err)
  );

  // the extra sync delay is what stretches asynchronous latency to five cycles
  event_sync u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (core_evt_in),
    .level_out  (core_lvl)
  );

  // instruction cycle divider
  logic [1:0] div_r, div_nxt;
  logic       tcy_en_r, tcy_en_nxt;
  always_comb begin
    div_nxt    = (div_r == 2'(CLKS_PER_TCY - 1)) ? 2'h0 : div_r + 2'h1;
    tcy_en_nxt = (div_nxt == 2'(CLKS_PER_TCY - 1));
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_r    <= 2'h0;
      tcy_en_r <= 1'b0;
    end else begin
      div_r    <= div_nxt;
      tcy_en_r <= tcy_en_nxt;
    end
  end

  // flag and enable registers
  logic                    gie_r, gie_nxt, peripheral_group_irq_enable_r, peripheral_group_irq_enable_nxt;
  logic [NUM_CORE_EVT-1:0] cen_r, cen_nxt, cflag_r, cflag_nxt, core_prev_r, core_rise;
  logic [7:0]              pf1_r, pf1_nxt, pf2_r, pf2_nxt, pe1_r, pe1_nxt, pe2_r, pe2_nxt;
  logic [ISTAT_W-1:0]      istat_r, istat_nxt, imask_r, imask_nxt, istat_set;
  logic                    wr_ctrl, wr_pf1, wr_pf2, wr_pe1, wr_pe2, wr_mask, rd_istat;
  logic                    irq_req, take, irq_nxt, irq_r;

  seq_state_t state_r, state_nxt;
  core_cmd_t  cmd_r, cmd_nxt;
  core_ctx_t  shadow_r, shadow_nxt;

  always_comb begin
    wr_ctrl   = req.we && req.wstrb0 && (req.waddr == OFS_CTRL);
    wr_pf1    = req.we && req.wstrb0 && (req.waddr == OFS_PFLAG1);
    wr_pf2    = req.we && req.wstrb0 && (req.waddr == OFS_PFLAG2);
    wr_pe1    = req.we && req.wstrb0 && (req.waddr == OFS_PEN1);
    wr_pe2    = req.we && req.wstrb0 && (req.waddr == OFS_PEN2);
    wr_mask   = req.we && req.wstrb0 && (req.waddr == OFS_IMASK);
    rd_istat  = req.re && (req.raddr == OFS_ISTAT);
    core_rise = core_lvl & ~core_prev_r;
    // hardware set wins over a software clear in the same cycle
    cflag_nxt = (wr_ctrl ? req.wdata[CTRL_CFLAG_LSB +: NUM_CORE_EVT] : cflag_r) | core_rise;
    pf1_nxt   = (wr_pf1 ? req.wdata : pf1_r) | periph_evt_in[7:0];
    pf2_nxt   = (wr_pf2 ? req.wdata : pf2_r) | periph_evt_in[15:8];
    cen_nxt   = wr_ctrl ? req.wdata[CTRL_CEN_LSB +: NUM_CORE_EVT] : cen_r;
    peripheral_group_irq_enable_nxt  = wr_ctrl ? req.wdata[CTRL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT] : peripheral_group_irq_enable_r;
    pe1_nxt   = wr_pe1 ? req.wdata : pe1_r;
    pe2_nxt   = wr_pe2 ? req.wdata : pe2_r;
    imask_nxt = wr_mask ? req.wdata[ISTAT_W-1:0] : imask_r;
    // flags stay set until software clears them, so a blocked request survives
    irq_req   = (|(cflag_r & cen_r)) || (peripheral_group_irq_enable_r && ((|(pf1_r & pe1_r)) || (|(pf2_r & pe2_r))));
    take      = tcy_en_r && (state_r == ST_RUN) && gie_r && irq_req && !return_from_irq_op_in;
  end

  // entry and return sequencer, one step per instruction cycle
  always_comb begin
    state_nxt  = state_r;
    cmd_nxt    = '0;
    shadow_nxt = shadow_r;
    gie_nxt    = wr_ctrl ? req.wdata[CTRL_GIE_BIT] : gie_r;
    case (state_r)
      ST_RUN: begin
        if (return_from_irq_op_in) begin
          cmd_nxt.pop     = 1'b1;
          cmd_nxt.restore = 1'b1;
          gie_nxt         = 1'b1;
        end else if (take) begin
          state_nxt     = ST_FLUSH;
          cmd_nxt.flush = 1'b1;
          gie_nxt       = 1'b0;
        end
      end
      ST_FLUSH: begin
        gie_nxt = 1'b0;
        if (tcy_en_r) begin
          state_nxt    = ST_PUSH;
          cmd_nxt.push = 1'b1;
          cmd_nxt.addr = pc_in;
          shadow_nxt   = ctx_in;
        end
      end
      ST_PUSH: begin
        gie_nxt = 1'b0;
        if (tcy_en_r) begin
          state_nxt       = ST_RUN;
          cmd_nxt.pc_load = 1'b1;
          cmd_nxt.addr    = IRQ_VECTOR;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    istat_set                    = '0;
    istat_set[ISTAT_ENTRY_BIT]   = cmd_nxt.pc_load;
    istat_set[ISTAT_RETURN_BIT]  = cmd_nxt.pop;
    istat_set[ISTAT_BLOCKED_BIT] = irq_req && !gie_r;
    istat_nxt = (rd_istat ? ISTAT_RST : istat_r) | istat_set;
    irq_nxt   = |(istat_nxt & imask_nxt);
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gie_r       <= 1'b0;
      peripheral_group_irq_enable_r      <= 1'b0;
      cen_r       <= '0;
      cflag_r     <= '0;
      core_prev_r <= '0;
      pf1_r       <= FLAG_RST;
      pf2_r       <= FLAG_RST;
      pe1_r       <= EN_RST;
      pe2_r       <= EN_RST;
      istat_r     <= ISTAT_RST;
      imask_r     <= IMASK_RST;
      irq_r       <= 1'b0;
      state_r     <= ST_RUN;
      cmd_r       <= '0;
      shadow_r    <= '0;
    end else begin
      gie_r       <= gie_nxt;
      peripheral_group_irq_enable_r      <= peripheral_group_irq_enable_nxt;
      cen_r       <= cen_nxt;
      cflag_r     <= cflag_nxt;
      core_prev_r <= core_lvl;
      pf1_r       <= pf1_nxt;
      pf2_r       <= pf2_nxt;
      pe1_r       <= pe1_nxt;
      pe2_r       <= pe2_nxt;
      istat_r     <= istat_nxt;
      imask_r     <= imask_nxt;
      irq_r       <= irq_nxt;
      state_r     <= state_nxt;
      cmd_r       <= cmd_nxt;
      shadow_r    <= shadow_nxt;
    end
  end

  // read decode; the state word is read only, unmapped offsets answer with an error
  always_comb begin
    rd_data = 8'h00;
    rd_err  = 1'b0;
    case (req.raddr)
      OFS_CTRL:   rd_data = {gie_r, peripheral_group_irq_enable_r, cen_r, 2'h0, cflag_r};
      OFS_PFLAG1: rd_data = pf1_r;
      OFS_PFLAG2: rd_data = pf2_r;
      OFS_PEN1:   rd_data = pe1_r;
      OFS_PEN2:   rd_data = pe2_r;
      OFS_ISTAT:  rd_data = {5'h00, istat_r};
      OFS_IMASK:  rd_data = {5'h00, imask_r};
      OFS_STATE:  rd_data = {6'h00, state_r != ST_RUN, irq_req};
      default:    rd_err  = 1'b1;
    endcase
    case (req.waddr)
      OFS_CTRL, OFS_PFLAG1, OFS_PFLAG2, OFS_PEN1, OFS_PEN2, OFS_ISTAT, OFS_IMASK, OFS_STATE: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  assign cmd_out        = cmd_r;
  assign shadow_ctx_out = shadow_r;
  assign gie_out        = gie_r;
  assign irq_out        = irq_r;

  // checks
  logic first_r;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_take;
    take;
  endsequence
  sequence s_entry_steps;
    ##1 cmd_r.flush ##4 cmd_r.push ##4 (cmd_r.pc_load && cmd_r.addr == IRQ_VECTOR);
  endsequence

  a_reset_disables: assert property (first_r |-> !gie_r && state_r == ST_RUN)
    else $error("interrupts not disabled after reset");
  a_take_needs_enable: assert property ((state_r == ST_FLUSH && $past(state_r) == ST_RUN) |-> $past(gie_r) && $past(irq_req))
    else $error("entry started without enables");
  a_flags_always_set: assert property (1'b1 |=> ({pf2_r, pf1_r} & $past(periph_evt_in)) == $past(periph_evt_in))
    else $error("peripheral event did not set its flag");
  a_entry_flush: assert property (s_take |=> cmd_r.flush && !gie_r && !cmd_r.push)
    else $error("entry did not flush and clear enable");
  a_push_save: assert property ((state_r == ST_FLUSH && tcy_en_r) |=> cmd_r.push && cmd_r.addr == $past(pc_in) && shadow_r == $past(ctx_in))
    else $error("push or shadow save wrong");
  a_entry_order: assert property (s_take |-> s_entry_steps)
    else $error("entry steps out of order or late");
  a_no_redirect: assert property ((state_r != ST_RUN) |-> !gie_r)
    else $error("global enable set during entry");
  a_return_restores: assert property ((return_from_irq_op_in && state_r == ST_RUN) |=> cmd_r.pop && cmd_r.restore && gie_r && !cmd_r.flush)
    else $error("return did not restore");
  a_irq_level: assert property (irq_out == $past(|(istat_nxt & imask_nxt)))
    else $error("interrupt output does not follow masked status");
endmodule : core_interrupt_sequencer

// [rtl/irq_seq_pkg.sv]
// irq_seq_pkg: constants, register map and carrier types for the interrupt sequencer
// assumes a 20 MHz core clock and an instruction cycle of four core clocks
package irq_seq_pkg;
  localparam int          CLK_PERIOD_NS     = 50;
  localparam int          TCY_NS            = 200;
  localparam int          CLKS_PER_TCY      = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          NUM_CORE_EVT      = 2;
  localparam int          NUM_PERIPH_EVT    = 16;
  localparam logic [14:0] IRQ_VECTOR        = 15'h0004;

  localparam logic [7:0]  OFS_CTRL          = 8'h00;
  localparam logic [7:0]  OFS_PFLAG1        = 8'h04;
  localparam logic [7:0]  OFS_PFLAG2        = 8'h08;
  localparam logic [7:0]  OFS_PEN1          = 8'h0c;
  localparam logic [7:0]  OFS_PEN2          = 8'h10;
  localparam logic [7:0]  OFS_ISTAT         = 8'h14;
  localparam logic [7:0]  OFS_IMASK         = 8'h18;
  localparam logic [7:0]  OFS_STATE         = 8'h1c;

  localparam int          CTRL_GIE_BIT      = 7;
  localparam int          CTRL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT     = 6;
  localparam int          CTRL_CEN_LSB      = 4;
  localparam int          CTRL_CFLAG_LSB    = 0;
  localparam int          ISTAT_ENTRY_BIT   = 0;
  localparam int          ISTAT_RETURN_BIT  = 1;
  localparam int          ISTAT_BLOCKED_BIT = 2;
  localparam int          ISTAT_W           = 3;

  localparam logic [7:0]  FLAG_RST          = 8'h00;
  localparam logic [7:0]  EN_RST            = 8'h00;
  localparam logic [ISTAT_W-1:0] ISTAT_RST  = 3'h0;
  localparam logic [ISTAT_W-1:0] IMASK_RST  = 3'h0;

  localparam logic [1:0]  AXI_OKAY          = 2'h0;
  localparam logic [1:0]  AXI_SLVERR        = 2'h2;

  typedef enum logic [1:0] {ST_RUN, ST_FLUSH, ST_PUSH} seq_state_t;

  typedef struct packed {
    logic [7:0] wreg;
    logic [7:0] status;
    logic [7:0] bsr;
    logic [7:0] pclath;
  } core_ctx_t;

  typedef struct packed {
    logic        flush;
    logic        push;
    logic        pc_load;
    logic        pop;
    logic        restore;
    logic [14:0] addr;
  } core_cmd_t;

  typedef struct packed {
    logic       we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic       wstrb0;
    logic       re;
    logic [7:0] raddr;
  } reg_req_t;
endpackage : irq_seq_pkg

// [rtl/event_sync.sv]
// event_sync: three-stage synchroniser for asynchronous core event pins
// assumes pins change slower than two core clocks; output moves once stages two and three agree
module event_sync
  import irq_seq_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic [NUM_CORE_EVT-1:0] async_in,
  output logic      [NUM_CORE_EVT-1:0] level_out
);
  genvar g;
  generate
    for (g = 0; g < NUM_CORE_EVT; g++) begin : g_sync
      logic s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
      always_comb begin
        lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
      end
      always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          s3_r  <= 1'b0;
          lvl_r <= 1'b0;
        end else begin
          s1_r  <= async_in[g];
          s2_r  <= s1_r;
          s3_r  <= s2_r;
          lvl_r <= lvl_nxt;
        end
      end
      assign level_out[g] = lvl_r;
    end
  endgenerate
endmodule : event_sync

// [rtl/axil_slave.sv]
// axil_slave: AXI4-Lite slave front end, one write and one read in flight
// assumes the register file answers rd_data_in and the error lines combinationally
module axil_slave
  import irq_seq_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output reg_req_t         req_out,
  input  wire logic [7:0]  rd_data_in,
  input  wire logic        rd_err_in,
  input  wire logic        wr_err_in
);
  // ready low means the channel's item is held here; arready low means the read response is still waiting
  logic        awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt, wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic        wstrb_r, wstrb_nxt, do_wr, do_rd;

  always_comb begin
    do_wr       = !awready_r && !wready_r && !bvalid_r;
    do_rd       = s_axi_arvalid_in && arready_r;
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    arready_nxt = arready_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (s_axi_awvalid_in && awready_r) begin
      awready_nxt = 1'b0;
      awaddr_nxt  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_r) begin
      wready_nxt = 1'b0;
      wdata_nxt  = s_axi_wdata_in[7:0];
      wstrb_nxt  = s_axi_wstrb_in[0];
    end
    if (bvalid_r && s_axi_bready_in) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_err_in ? AXI_SLVERR : AXI_OKAY;
    end
    if (rvalid_r && s_axi_rready_in) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
    if (do_rd) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rdata_nxt   = rd_data_in;
      rresp_nxt   = rd_err_in ? AXI_SLVERR : AXI_OKAY;
    end
    req_out.we     = do_wr;
    req_out.waddr  = awaddr_r;
    req_out.wdata  = wdata_r;
    req_out.wstrb0 = wstrb_r;
    req_out.re     = do_rd;
    req_out.raddr  = s_axi_araddr_in;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      arready_r <= 1'b1;
      awaddr_r  <= 8'h00;
      wdata_r   <= 8'h00;
      wstrb_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= AXI_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= AXI_OKAY;
      rdata_r   <= 8'h00;
    end else begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      arready_r <= arready_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign s_axi_awready_out = awready_r;
  assign s_axi_wready_out  = wready_r;
  assign s_axi_arready_out = arready_r;
  assign s_axi_bvalid_out  = bvalid_r;
  assign s_axi_bresp_out   = bresp_r;
  assign s_axi_rvalid_out  = rvalid_r;
  assign s_axi_rresp_out   = rresp_r;
  assign s_axi_rdata_out   = {24'h000000, rdata_r};
endmodule : axil_slave

// [bench/core_model.sv]
// core_model: behavioural core on the far side of the sequencer's core link
// assumes the bench asks for a return by ret_req_in; pc and context move every clock
module core_model
  import irq_seq_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      sys_rst_in,
  input  wire core_cmd_t cmd_in,
  input  wire core_ctx_t shadow_in,
  input  wire logic      ret_req_in,
  output logic [14:0]    pc_out,
  output core_ctx_t      ctx_out,
  output logic           return_from_irq_op_out
);
  logic [14:0] stack_r;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pc_out     <= 15'h0100;
      stack_r    <= 15'h0000;
      ctx_out    <= '0;
      return_from_irq_op_out <= 1'b0;
    end else begin
      return_from_irq_op_out <= ret_req_in;
      if (cmd_in.push) stack_r <= cmd_in.addr;
      if (cmd_in.pc_load) pc_out <= cmd_in.addr;
      else if (cmd_in.pop) pc_out <= stack_r;
      else pc_out <= pc_out + 15'h0001;
      // context never stands still, so a capture on the wrong cycle is caught
      if (cmd_in.restore) ctx_out <= shadow_in;
      else ctx_out <= {pc_out[7:0], ~pc_out[7:0], 8'h5a, 1'b0, pc_out[14:8]};
    end
  end
endmodule : core_model

// [bench/test_core_interrupt_sequencer.sv]
// test_core_interrupt_sequencer: register, entry, pending and return checks
// assumes core_model plays the core and the bench plays the bus master and software
module test_core_interrupt_sequencer
  import irq_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [19:0] M_FLUSH = 20'h80000, M_PUSH = 20'h40000, M_LOAD = 20'h20000, M_POP = 20'h10000;
  logic clk_in = 0, sys_rst_in = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, ret_req = 0;
  logic awr, wr_r, bv, arr, rv, return_from_irq_op, global_irq_enable, irq;
  logic [7:0] aa = 0, ra = 0, d;
  logic [31:0] wd = 0, rd;
  logic [1:0] bresp, rresp, ce = 0;
  logic [15:0] pe = 0;
  logic [14:0] pc, prev_pc, pa;
  core_ctx_t ctx, prev_ctx, shadow;
  core_cmd_t cmd;
  int errors = 0, comparisons = 0, n;
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    prev_pc <= pc;
    prev_ctx <= ctx;
  end
  core_interrupt_sequencer core_interrupt_sequencer_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .s_axi_awaddr_in(aa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ra), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rr), .periph_evt_in(pe), .core_evt_in(ce), .return_from_irq_op_in(return_from_irq_op), .pc_in(pc),
    .ctx_in(ctx), .cmd_out(cmd), .shadow_ctx_out(shadow), .gie_out(global_irq_enable), .irq_out(irq));
  core_model core_model_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd), .shadow_in(shadow),
    .ret_req_in(ret_req), .pc_out(pc), .ctx_out(ctx), .return_from_irq_op_out(return_from_irq_op));
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic limit(input int k);
    if (k >= 40) begin
      errors++;
      $display("wrong value at %0t: no answer", $time);
      end_of_test();
    end
  endtask : limit
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    int k;
    aa <= a;
    wd <= {24'h0, v};
    awv <= 1;
    wv <= 1;
    br <= 1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_in);
      if (awr) awv <= 0;
      if (wr_r) wv <= 0;
      if (bv === 1'b1) break;
    end
    limit(k);
    // bready stays high between writes so a back-to-back call never drops and raises it in one step
    chk(bresp, er, "write response");
  endtask : wr
  task automatic rdt(input logic [7:0] a, input logic [1:0] er, output logic [7:0] v);
    int k;
    ra <= a;
    arv <= 1;
    rr <= 1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_in);
      if (arr) arv <= 0;
      if (rv === 1'b1) break;
    end
    limit(k);
    v = rd[7:0];
    chk(rresp, er, "read response");
  endtask : rdt
  task automatic wait_cmd(input logic [19:0] m, output int k);
    for (k = 0; k < 40; k++) begin
      @(posedge clk_in);
      if ((cmd & m) !== 20'h0) break;
    end
    limit(k);
  endtask : wait_cmd
  task automatic quiet(input string m);
    repeat (16) begin
      @(posedge clk_in);
      chk(cmd.flush, 1'b0, m);
    end
  endtask : quiet
  task automatic isr_return(input logic [7:0] a);
    wr(a, 8'h00, AXI_OKAY);
    ret_req <= 1;
    @(posedge clk_in);
    ret_req <= 0;
    wait_cmd(M_POP, n);
    chk(global_irq_enable, 1'b1, "gie after return");
    chk(cmd.restore, 1'b1, "restore with pop");
  endtask : isr_return
  task automatic latency(input logic [15:0] p, input logic [1:0] c, input int lo, input int hi);
    pe <= p;
    ce <= c;
    @(posedge clk_in);
    pe <= 0;
    wait_cmd(M_LOAD, n);
    // clocks from event to vector execution, rounded up to whole instruction cycles
    if ((n + 4) / 4 < lo || (n + 4) / 4 > hi) chk((n + 4) / 4, lo, "vector latency");
    else chk(1, 1, "vector latency");
  endtask : latency
  initial begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 0;
    @(posedge clk_in);
    chk(global_irq_enable, 1'b0, "gie after reset");
    rdt(OFS_CTRL, AXI_OKAY, d);
    chk(d, 8'h00, "ctrl after reset");
    rdt(8'h20, AXI_SLVERR, d);
    wr(8'h20, 8'hff, AXI_SLVERR);
    $display("test reset and map done");
    pe <= 16'h0001;
    @(posedge clk_in);
    pe <= 0;
    rdt(OFS_PFLAG1, AXI_OKAY, d);
    chk(d, 8'h01, "flag with enables off");
    wr(OFS_PEN1, 8'h01, AXI_OKAY);
    wr(OFS_IMASK, 8'h01, AXI_OKAY);
    wr(OFS_CTRL, 8'h80, AXI_OKAY);
    quiet("no entry without group enable");
    wr(OFS_CTRL, 8'hc0, AXI_OKAY);
    wait_cmd(M_FLUSH, n);
    chk(global_irq_enable, 1'b0, "gie cleared on entry");
    wait_cmd(M_PUSH, n);
    pa = cmd.addr;
    chk(cmd.addr, prev_pc, "pushed pc");
    chk(shadow, prev_ctx, "shadow capture");
    wait_cmd(M_LOAD, n);
    chk(cmd.addr, IRQ_VECTOR, "vector address");
    @(posedge clk_in);
    @(posedge clk_in);
    chk(irq, 1'b1, "irq on entry");
    $display("test entry done");
    pe <= 16'h0002;
    @(posedge clk_in);
    pe <= 0;
    quiet("no redirect in service");
    rdt(OFS_PFLAG1, AXI_OKAY, d);
    chk(d, 8'h03, "flags in service");
    rdt(OFS_ISTAT, AXI_OKAY, d);
    chk(d[0], 1'b1, "entry status");
    @(posedge clk_in);
    chk(irq, 1'b0, "irq after status read");
    isr_return(OFS_PFLAG1);
    @(posedge clk_in);
    chk(pc, pa, "pc popped");
    chk(ctx, shadow, "context restored");
    quiet("no re-entry with flags clear");
    $display("test return done");
    wr(OFS_IMASK, 8'h00, AXI_OKAY);
    latency(16'h0001, 2'h0, 3, 4);
    chk(irq, 1'b0, "masked irq");
    isr_return(OFS_PFLAG1);
    wr(OFS_CTRL, 8'h90, AXI_OKAY);
    latency(16'h0000, 2'h1, 3, 5);
    ce <= 0;
    isr_return(OFS_CTRL);
    $display("test latency done");
    end_of_test();
  end
endmodule : test_core_interrupt_sequencer
